//--- static_mem_pkg.sv
/*
 * Static memory strobe timing: register map, field layout, reset values.
 * Assumes a 32-bit classic Wishbone register bus and a 125 MHz master clock.
 */
package static_mem_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned num_cs = 8;
    localparam logic [7:0] cfg_base_addr = 8'h00;
    localparam logic [7:0] cfg_last_addr = 8'h1c;
    localparam logic [31:0] cfg_reset = 32'h00002000;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned wait_count_lsb = 0;
    localparam int unsigned wait_en_bit = 7;
    localparam int unsigned float_lsb = 8;
    localparam int unsigned byte_access_bit = 12;
    localparam int unsigned width_lsb = 13;
    localparam int unsigned read_proto_bit = 15;
    localparam int unsigned shorten_lsb = 16;
    localparam int unsigned setup_lsb = 24;
    localparam int unsigned hold_lsb = 28;
    localparam logic [31:0] cfg_write_mask = 32'h7703ffff;
    // ----------------------------------------------------------------
    // Bus width codes
    // ----------------------------------------------------------------
    localparam logic [1:0] width_16 = 2'h1;
    localparam logic [1:0] width_8 = 2'h2;
    // Access phase sequence
    typedef enum logic [2:0] {
        phase_idle, phase_lead, phase_setup, phase_pulse, phase_hold, phase_trail, phase_float
    } phase_type;
endpackage

//--- strobe_sequencer.sv
/*
 * One external access: chip select, strobes and phase counting in half cycles.
 * Assumes start_i pulses once per access with a stable configuration.
 */
`timescale 1ns/1ps
module strobe_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic early_i,
    input wire logic [1:0] shorten_i,
    input wire logic [2:0] setup_i,
    input wire logic [2:0] hold_i,
    input wire logic wait_en_i,
    input wire logic [6:0] wait_count_i,
    input wire logic [3:0] float_i,
    output logic cs_active_o,
    output logic strobe_active_o,
    output logic done_o,
    output logic busy_o
);
    // Half-cycle ticks; strobes switch on half cycles via count granularity
    static_mem_pkg::phase_type phase, next_phase;
    logic [8:0] cnt, next_cnt;
    logic [8:0] strobe_len, setup_len, hold_len;

    always_comb begin
        setup_len = {5'h0, setup_i, 1'b0} + 9'h001;
        if (setup_i == 3'h0 && early_i && !write_i) begin
            setup_len = 9'h000;
        end
        if (wait_en_i) begin
            strobe_len = {1'b0, wait_count_i, 1'b0} + 9'h002;
        end else begin
            strobe_len = 9'h001;
        end
        // All reads with wait states end half a cycle later
        if (!write_i && wait_en_i) begin
            strobe_len = strobe_len + 9'h001;
        end
        if (!write_i && early_i) begin
            strobe_len = strobe_len + 9'h001;
        end
        hold_len = {5'h0, hold_i, 1'b0};
        if (hold_i == 3'h0 && write_i) begin
            hold_len = 9'h001;
        end
    end

    always_comb begin
        next_phase = phase;
        next_cnt = cnt - 9'h001;
        case (phase)
            static_mem_pkg::phase_idle: begin
                next_cnt = 9'h000;
                if (start_i) begin
                    next_phase = static_mem_pkg::phase_lead;
                    next_cnt = {6'h0, shorten_i, 1'b0};
                end
            end
            static_mem_pkg::phase_lead: if (cnt == 9'h000) begin
                if (setup_len != 9'h000) begin
                    next_phase = static_mem_pkg::phase_setup;
                    next_cnt = setup_len;
                end else begin
                    next_phase = static_mem_pkg::phase_pulse;
                    next_cnt = strobe_len;
                end
            end
            // Setup, pulse, hold and float last exactly their length in ticks; trail lasts one tick more
            static_mem_pkg::phase_setup: if (cnt <= 9'h001) begin
                next_phase = static_mem_pkg::phase_pulse;
                next_cnt = strobe_len;
            end
            static_mem_pkg::phase_pulse: if (cnt <= 9'h001) begin
                if (hold_len != 9'h000) begin
                    next_phase = static_mem_pkg::phase_hold;
                    next_cnt = hold_len;
                end else begin
                    next_phase = static_mem_pkg::phase_trail;
                    next_cnt = {6'h0, shorten_i, 1'b0};
                end
            end
            static_mem_pkg::phase_hold: if (cnt <= 9'h001) begin
                next_phase = static_mem_pkg::phase_trail;
                next_cnt = {6'h0, shorten_i, 1'b0};
            end
            static_mem_pkg::phase_trail: if (cnt == 9'h000) begin
                if (float_i != 4'h0) begin
                    next_phase = static_mem_pkg::phase_float;
                    next_cnt = {4'h0, float_i, 1'b0};
                end else begin
                    next_phase = static_mem_pkg::phase_idle;
                end
            end
            static_mem_pkg::phase_float: if (cnt <= 9'h001) begin
                next_phase = static_mem_pkg::phase_idle;
            end
            default: next_phase = static_mem_pkg::phase_idle;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= static_mem_pkg::phase_idle;
            cnt <= 9'h000;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
        end
    end

    always_comb begin
        cs_active_o = phase == static_mem_pkg::phase_setup || phase == static_mem_pkg::phase_pulse
            || phase == static_mem_pkg::phase_hold;
        strobe_active_o = phase == static_mem_pkg::phase_pulse;
        done_o = phase == static_mem_pkg::phase_trail && cnt == 9'h000;
        busy_o = phase != static_mem_pkg::phase_idle;
    end
endmodule

//--- static_mem_ctrl.sv
/*
 * Static memory controller timing block: eight chip select configuration
 * registers on Wishbone, and an access engine driving the external pins.
 * Assumes an asynchronous external memory model; timing runs in half-cycle
 * ticks of clk_i, so one tick of the sequencer equals half a memory cycle.
 */
// Our own choices: the Wishbone register port and the placing of the registers.
// Contract
// - Bus width code 01 selects 16 bits, 10 selects 8 bits, others are reserved.
// - Read protocol bit 0 gives standard reads and 1 gives early reads.
// - Chip select shortening N delays select by N cycles and drops it N cycles early.
// - Setup N gives N plus half cycles; zero gives half, or none for early reads.
// - Hold N keeps N cycles after strobes; zero gives none on read, half on write.
// - Wait count X gives X+1 wait states and reads back zero when disabled.
// - The bus stays busy for the float time after each access.
// - Byte access type matters only on a 16-bit bus, choosing two bytes or one halfword device.
`timescale 1ns/1ps
module static_mem_ctrl #(
    parameter int unsigned addr_width = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [2:0] mem_cs_i,
    input wire logic [addr_width-1:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic [1:0] mem_be_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_ack_o,
    output logic [static_mem_pkg::num_cs-1:0] chip_select_n_o,
    output logic read_strobe_n_o,
    output logic [1:0] write_strobe_n_o,
    output logic [addr_width-1:0] ext_addr_o,
    output logic [15:0] ext_data_o,
    output logic ext_data_oe_n_o,
    input wire logic [15:0] ext_data_i,
    output logic bus_busy_o
);
    localparam int unsigned num_cs_w = static_mem_pkg::num_cs;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [31:0] cfg [num_cs_w];
    logic [31:0] next_cfg [num_cs_w];
    logic [31:0] next_dat;
    logic next_ack;

    function automatic logic [31:0] read_view(input logic [31:0] r);
        logic [31:0] v;
        v = r & static_mem_pkg::cfg_write_mask;
        if (!v[static_mem_pkg::wait_en_bit]) begin
            v[6:0] = 7'h00;
        end
        return v;
    endfunction

    // Unmapped offsets still answer, so a stray access never stalls the bus
    logic hit;
    logic [2:0] idx;
    assign hit = adr_i <= static_mem_pkg::cfg_last_addr && adr_i[1:0] == 2'h0;
    assign idx = adr_i[4:2];

    always_comb begin
        for (int i = 0; i < num_cs_w; i++) begin
            next_cfg[i] = cfg[i];
        end
        next_ack = cyc_i && stb_i && !ack_o;
        next_dat = 32'h00000000;
        if (next_ack && hit) begin
            next_dat = read_view(cfg[idx]);
            if (we_i) begin
                for (int b = 0; b < 4; b++) begin
                    if (sel_i[b]) begin
                        next_cfg[idx][b*8 +: 8] = dat_i[b*8 +: 8];
                    end
                end
                next_cfg[idx] = next_cfg[idx] & static_mem_pkg::cfg_write_mask;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < num_cs_w; i++) begin
                cfg[i] <= static_mem_pkg::cfg_reset;
            end
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            for (int i = 0; i < num_cs_w; i++) begin
                cfg[i] <= next_cfg[i];
            end
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // ----------------------------------------------------------------
    // Access engine
    // ----------------------------------------------------------------
    logic [31:0] cur;
    logic [2:0] cur_cs, next_cs;
    logic cur_we, next_we;
    logic start, next_start;
    logic cs_active, strobe_active, seq_done, seq_busy;
    logic [15:0] next_rdata;
    logic next_mem_ack;
    logic [addr_width-1:0] next_addr;
    logic [15:0] next_wdata;
    logic [1:0] cur_be, next_be;
    logic [1:0] bw;
    logic early;

    // Live view of the row; rewriting it mid-access retimes that access
    assign cur = cfg[cur_cs];
    assign bw = cur[static_mem_pkg::width_lsb +: 2];
    assign early = cur[static_mem_pkg::read_proto_bit];

    strobe_sequencer u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(start),
        .write_i(cur_we),
        .early_i(early),
        .shorten_i(cur[static_mem_pkg::shorten_lsb +: 2]),
        .setup_i(cur[static_mem_pkg::setup_lsb +: 3]),
        .hold_i(cur[static_mem_pkg::hold_lsb +: 3]),
        .wait_en_i(cur[static_mem_pkg::wait_en_bit]),
        .wait_count_i(cur[static_mem_pkg::wait_count_lsb +: 7]),
        .float_i(cur[static_mem_pkg::float_lsb +: 4]),
        .cs_active_o(cs_active),
        .strobe_active_o(strobe_active),
        .done_o(seq_done),
        .busy_o(seq_busy)
    );

    always_comb begin
        next_cs = cur_cs;
        next_we = cur_we;
        next_addr = ext_addr_o;
        next_wdata = ext_data_o;
        next_be = cur_be;
        next_start = 1'b0;
        next_rdata = mem_rdata_o;
        next_mem_ack = 1'b0;
        if (mem_req_i && !seq_busy && !start && !mem_ack_o) begin
            next_cs = mem_cs_i;
            next_we = mem_we_i;
            next_addr = mem_addr_i;
            next_wdata = mem_wdata_i;
            next_be = mem_be_i;
            next_start = 1'b1;
        end
        // Latch read data from the pin view of the strobe
        // The pin lags the phase, so a one-tick pulse is still caught
        if (!read_strobe_n_o) begin
            // 8-bit bus uses low lane only
            next_rdata = (bw == static_mem_pkg::width_8) ? {8'h00, ext_data_i[7:0]} : ext_data_i;
        end
        if (seq_done) begin
            next_mem_ack = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_cs <= 3'h0;
            cur_we <= 1'b0;
            cur_be <= 2'h0;
            start <= 1'b0;
            ext_addr_o <= '0;
            ext_data_o <= 16'h0000;
            mem_rdata_o <= 16'h0000;
            mem_ack_o <= 1'b0;
            chip_select_n_o <= '1;
            read_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 2'h3;
            ext_data_oe_n_o <= 1'b1;
            bus_busy_o <= 1'b0;
        end else begin
            cur_cs <= next_cs;
            cur_we <= next_we;
            cur_be <= next_be;
            start <= next_start;
            ext_addr_o <= next_addr;
            ext_data_o <= next_wdata;
            mem_rdata_o <= next_rdata;
            mem_ack_o <= next_mem_ack;
            for (int i = 0; i < num_cs_w; i++) begin
                chip_select_n_o[i] <= !(cs_active && cur_cs == i[2:0]);
            end
            read_strobe_n_o <= !(strobe_active && !cur_we);
            // per-byte strobes for two 8-bit parts
            if (bw == static_mem_pkg::width_16 && !cur[static_mem_pkg::byte_access_bit]) begin
                write_strobe_n_o <= ~({2{strobe_active && cur_we}} & cur_be);
            end else begin
                write_strobe_n_o <= {2{!(strobe_active && cur_we)}};
            end
            ext_data_oe_n_o <= !(cs_active && cur_we);
            bus_busy_o <= seq_busy;
        end
    end
endmodule

//--- static_mem_ctrl_properties.sv
/* Port checker for the static memory timing block.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module static_mem_ctrl_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic mem_req_i,
    input wire logic mem_ack_o,
    input wire logic [7:0] chip_select_n_o,
    input wire logic read_strobe_n_o,
    input wire logic [1:0] write_strobe_n_o,
    input wire logic ext_data_oe_n_o,
    input wire logic bus_busy_o
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic strb;
    logic idle;
    assign strb = !read_strobe_n_o || write_strobe_n_o != 2'h3;
    assign idle = chip_select_n_o == 8'hff;
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("register access not answered");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("register ack longer than one cycle");
    mem_pulse_a: assert property (mem_ack_o |=> !mem_ack_o)
        else $error("memory ack longer than one cycle");
    ack_after_a: assert property (mem_ack_o |-> mem_req_i && idle && !strb)
        else $error("memory ack before sequence end");
    strobe_cs_a: assert property (strb |-> !idle && bus_busy_o)
        else $error("strobe outside select");
    one_cs_a: assert property ($onehot0(~chip_select_n_o))
        else $error("several selects low");
    float_end_a: assert property ($fell(bus_busy_o) |-> idle && !strb)
        else $error("bus freed during access");
    read_float_a: assert property (!read_strobe_n_o |-> ext_data_oe_n_o)
        else $error("data driven during read");
    write_drive_a: assert property (write_strobe_n_o != 2'h3 |-> !ext_data_oe_n_o)
        else $error("data not driven during write");
    reset_idle_a: assert property (disable iff (1'b0) rst_i |=> idle && !ack_o && !mem_ack_o)
        else $error("outputs active after reset");
    cover property ($fell(read_strobe_n_o));
    cover property (write_strobe_n_o == 2'h2);
    cover property (mem_ack_o ##1 bus_busy_o);
endmodule

bind static_mem_ctrl static_mem_ctrl_props chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .mem_req_i(mem_req_i), .mem_ack_o(mem_ack_o),
    .chip_select_n_o(chip_select_n_o), .read_strobe_n_o(read_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o), .ext_data_oe_n_o(ext_data_oe_n_o),
    .bus_busy_o(bus_busy_o));

//--- ext_mem_model.sv
/* Asynchronous memory on the external pins, sixteen halfwords.
   Assumes low active selects and strobes; idle data toggles. */
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic clk_i,
    input wire logic [7:0] cs_n_i,
    input wire logic rd_n_i,
    input wire logic [1:0] wr_n_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic sel;
    assign sel = cs_n_i != 8'hff;
    always @(posedge clk_i) begin
        last <= data_o;
        if (sel && !wr_n_i[0])
            mem[addr_i[3:0]][7:0] <= data_i[7:0];
        if (sel && !wr_n_i[1])
            mem[addr_i[3:0]][15:8] <= data_i[15:8];
    end
    // Released bus shows a moving pattern, never the last word
    assign data_o = (sel && !rd_n_i) ? mem[addr_i[3:0]] : ~last;
endmodule

//--- tb_static_mem_ctrl.sv
/* Self-checking bench: registers over Wishbone, strobe timing, float.
   Assumes the bound checker and the external memory model. */
`timescale 1ns/1ps
module tb_static_mem_ctrl;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, mem_ack_o, rd_n, oe_n, busy, seen = 0;
    logic mem_req_i = 0, mem_we_i = 0;
    logic [23:0] mem_addr_i = 24'h0, ext_addr;
    logic [15:0] mem_wdata_i = 16'h0, mem_rdata_o, ext_do, ext_di;
    logic [1:0] mem_be_i = 2'h3, wr_n;
    logic [7:0] cs_n;
    int err_count = 0, checked = 0, cyc_cnt = 0;
    int n [6] = '{default: 0};
    static_mem_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .mem_req_i(mem_req_i), .mem_we_i(mem_we_i), .mem_cs_i(3'h1),
        .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .mem_be_i(mem_be_i),
        .mem_rdata_o(mem_rdata_o), .mem_ack_o(mem_ack_o), .chip_select_n_o(cs_n),
        .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .ext_addr_o(ext_addr),
        .ext_data_o(ext_do), .ext_data_oe_n_o(oe_n), .ext_data_i(ext_di),
        .bus_busy_o(busy));
    ext_mem_model mem (.clk_i(clk_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .addr_i(ext_addr), .data_i(ext_do), .data_o(ext_di));
    initial forever #4 clk_i = ~clk_i;
    // ----
    // Phase counters: 0 lead, 1 setup, 2 pulse, 3 hold, 4 tail, 5 upper lane
    // ----
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_count++;
            end_sim;
        end
        if (mem_req_i && !busy) begin
            n <= '{default: 0};
            seen <= 0;
        end else if (!rd_n || wr_n != 2'h3) begin
            n[2] <= n[2] + 1;
            seen <= 1;
        end else if (cs_n != 8'hff)
            n[seen ? 3 : 1] <= n[seen ? 3 : 1] + 1;
        else if (busy)
            n[seen ? 4 : 0] <= n[seen ? 4 : 0] + 1;
        if (!wr_n[1])
            n[5] <= n[5] + 1;
    end
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    // Row: write, early, setup, hold, wait enable and count
    function automatic logic [31:0] cfg(input logic [15:0] r, input logic [1:0] wd,
            input logic [1:0] sh, input logic [3:0] f);
        return {1'b0, r[10:8], 1'b0, r[13:11], 6'h0, sh, r[14], wd, 1'b1, f, r[7:0]};
    endfunction
    task automatic acc(input logic w, input logic [3:0] a, input logic [1:0] be);
        @(posedge clk_i);
        mem_req_i <= 1;
        mem_we_i <= w;
        mem_addr_i <= {20'h0, a};
        mem_wdata_i <= 16'h5a00 + a * 16'h0111;
        mem_be_i <= be;
        do begin
            @(posedge clk_i);
        end while (mem_ack_o !== 1'b1);
        mem_req_i <= 0;
        do begin
            @(posedge clk_i);
        end while (busy !== 1'b0);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            wb(0, 8'(i * 4), 0, q);
            cmp("reset", 32'h00002000, q);
        end
        wb(1, 8'h0c, 32'hffffffff, q);
        wb(0, 8'h0c, 0, q);
        cmp("mask", 32'h7703ffff, q);
        wb(1, 8'h0c, 32'h0000207f, q);
        wb(0, 8'h0c, 0, q);
        cmp("count off", 32'h00002000, q);
        wb(0, 8'h20, 0, q);
        cmp("unmapped", 0, q);
    endtask
    task automatic t_time;
        logic [31:0] q;
        logic [15:0] r;
        int st;
        // no setup in early reads, no lone setup
        logic [15:0] rows [8] = '{16'h9100, 16'h0b00, 16'h8083, 16'h0083,
            16'h4000, 16'h4083, 16'h8000, 16'h0000};
        logic [3:0] ad [8] = '{1, 1, 2, 2, 1, 2, 3, 3};
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            wb(1, 8'h04, cfg(r, 2'h1, 2'h0, 4'h0), q);
            acc(r[15], ad[i], 2'h3);
            st = (r[7] ? 2 * r[6:0] + 2 : 1) + (r[15] ? 0 : r[14] + r[7]);
            cmp("setup", r[14] ? 0 : 2 * r[13:11] + 1, n[1]);
            cmp("pulse", st, n[2]);
            cmp("hold", r[10:8] ? 2 * r[10:8] : r[15], n[3]);
            if (!r[15])
                cmp("rdata", 16'h5a00 + ad[i] * 16'h0111, mem_rdata_o);
        end
    endtask
    task automatic t_short;
        logic [31:0] q;
        int lead;
        int tail;
        for (int s = 0; s < 4; s++) begin
            wb(1, 8'h04, cfg(16'h8085, 2'h1, 2'(s), 4'h0), q);
            acc(1, 4'h4, 2'h3);
            lead = s ? lead : n[0];
            tail = s ? tail : n[4];
            cmp("lead", lead + 2 * s, n[0]);
            cmp("trail", tail + 2 * s, n[4]);
            cmp("select", 14, n[1] + n[2] + n[3]);
        end
    endtask
    task automatic t_float;
        logic [31:0] q;
        int tail;
        wb(1, 8'h04, cfg(16'h8000, 2'h1, 2'h0, 4'h0), q);
        acc(1, 4'h5, 2'h3);
        tail = n[4];
        wb(1, 8'h04, cfg(16'h8000, 2'h1, 2'h0, 4'hf), q);
        acc(1, 4'h5, 2'h3);
        cmp("float", tail + 30, n[4]);
    endtask
    task automatic t_width;
        logic [31:0] q;
        wb(1, 8'h04, cfg(16'h8000, 2'h1, 2'h0, 4'h0) & 32'hffffefff, q);
        acc(1, 4'h6, 2'h1);
        cmp("upper lane", 0, n[5]);
        wb(1, 8'h04, cfg(16'h0000, 2'h2, 2'h0, 4'h0), q);
        acc(0, 4'h2, 2'h3);
        cmp("byte read", 32'h00000022, mem_rdata_o);
        acc(0, 4'h6, 2'h3);
        cmp("lower lane", 32'h00000066, mem_rdata_o);
    endtask
    task automatic end_sim;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        t_regs;
        t_time;
        t_short;
        t_float;
        t_width;
        end_sim;
    end
endmodule
